// [hdl/ncb_host.v]
// Purpose: Host sequencer for copy-back, ID read, status and ECC status
// Assumes: One NAND device on an x8 port, synchronous sampling of ready_busy_pin
// Notes: One operation at a time; busy waits poll the pin, not status
`timescale 1ns/100ps
`include "ncb_defs.vh"
// Behaviour
// - Check status or data after read busy
// - Copy-back program 85h with destination, no reload
// - Random data input patches buffer bytes
// - Source and destination in same district
// - Pass/fail valid only once ready
// - Only 70h, 71h, FFh while busy
module ncb_host (
    input wire clk_sys,
    input wire reset,
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [31:0] op_src_addr,
    input wire [31:0] op_dst_addr,
    input wire [15:0] op_column,
    input wire [7:0] op_data,
    input wire [7:0] port_in,
    input wire ready_busy_pin,
    output reg op_ready_r,
    output reg op_done_r,
    output reg op_error_r,
    output reg [7:0] result_r,
    output reg result_valid_r,
    output reg [7:0] device_status_r,
    output reg [7:0] ecc_result_status_r,
    output reg [3:0] id_chip_count_r,
    output reg [4:0] id_cell_levels_r,
    output reg [3:0] id_page_kb_r,
    output reg [9:0] id_block_kb_r,
    output reg id_wide_r,
    output reg cle,
    output reg ale,
    output reg write_strobe_n,
    output reg read_strobe_n,
    output reg [7:0] port_out,
    output reg port_oe
);
    localparam K_CMD = 2'd0;
    localparam K_ADR = 2'd1;
    localparam K_WR = 2'd2;
    localparam K_RD = 2'd3;
    localparam S_IDLE = 4'd0;
    localparam S_ISSUE = 4'd1;
    localparam S_WAIT = 4'd2;
    localparam S_WB = 4'd3;
    localparam S_BUSY = 4'd4;
    localparam S_DONE = 4'd5;
    reg [3:0] state_r;
    reg [3:0] step_r;
    reg [2:0] op_r;
    reg [31:0] src_r;
    reg [31:0] dst_r;
    reg [15:0] col_r;
    reg [7:0] data_r;
    reg [31:0] wait_r;
    reg [2:0] idx_r;
    reg err_r;
    reg st_go;
    reg [1:0] st_kind;
    reg [7:0] st_data;
    reg last_step;
    reg busy_after;
    wire st_done;
    wire [7:0] st_rdata;
    wire s_cle;
    wire s_ale;
    wire s_we_n;
    wire s_re_n;
    wire [7:0] s_out;
    wire s_oe;
    // Byte sequence for each operation; step index walks it
    always @* begin
        st_kind = K_CMD;
        st_data = 8'h00;
        last_step = 1'b0;
        busy_after = 1'b0;
        case (op_r)
            `NCB_OP_COPY_READ: begin
                case (step_r)
                    4'd0: st_data = `NCB_CMD_READ0;
                    4'd1: begin st_kind = K_ADR; st_data = 8'h00; end
                    4'd2: begin st_kind = K_ADR; st_data = 8'h00; end
                    4'd3: begin st_kind = K_ADR; st_data = src_r[7:0]; end
                    4'd4: begin st_kind = K_ADR; st_data = src_r[15:8]; end
                    4'd5: begin st_kind = K_ADR; st_data = src_r[23:16]; end
                    default: begin
                        st_data = `NCB_CMD_CB_READ;
                        last_step = 1'b1;
                        busy_after = 1'b1;
                    end
                endcase
            end
            `NCB_OP_COPY_PROG, `NCB_OP_PATCH: begin
                case (step_r)
                    4'd0: st_data = `NCB_CMD_CB_DATA;
                    4'd1: begin st_kind = K_ADR; st_data = col_r[7:0]; end
                    4'd2: begin st_kind = K_ADR; st_data = col_r[15:8]; end
                    4'd3: begin
                        st_kind = (op_r == `NCB_OP_PATCH) ? K_WR : K_ADR;
                        st_data = (op_r == `NCB_OP_PATCH) ? data_r : dst_r[7:0];
                        last_step = (op_r == `NCB_OP_PATCH);
                    end
                    4'd4: begin st_kind = K_ADR; st_data = dst_r[15:8]; end
                    4'd5: begin st_kind = K_ADR; st_data = dst_r[23:16]; end
                    default: begin
                        st_data = `NCB_CMD_PROG_CFM;
                        last_step = 1'b1;
                        busy_after = 1'b1;
                    end
                endcase
            end
            `NCB_OP_READ_ID: begin
                case (step_r)
                    4'd0: st_data = `NCB_CMD_READ_ID;
                    4'd1: begin st_kind = K_ADR; st_data = 8'h00; end
                    default: begin
                        st_kind = K_RD;
                        last_step = (idx_r == (`NCB_ID_BYTES - 3'd1));
                    end
                endcase
            end
            `NCB_OP_STATUS, `NCB_OP_ECC_STATUS: begin
                if (step_r == 4'd0) begin
                    st_data = (op_r == `NCB_OP_STATUS) ? `NCB_CMD_STATUS : `NCB_CMD_ECC_STAT;
                end else begin
                    st_kind = K_RD;
                    last_step = 1'b1;
                end
            end
            default: begin
                st_data = `NCB_CMD_RESET;
                last_step = 1'b1;
                busy_after = 1'b1;
            end
        endcase
    end
    always @(posedge clk_sys) begin
        if (reset) begin
            state_r <= S_IDLE;
            step_r <= 4'd0;
            op_r <= 3'd0;
            src_r <= 32'h0000_0000;
            dst_r <= 32'h0000_0000;
            col_r <= 16'h0000;
            data_r <= 8'h00;
            wait_r <= 32'h0000_0000;
            idx_r <= 3'd0;
            err_r <= 1'b0;
            op_ready_r <= 1'b0;
            op_done_r <= 1'b0;
            op_error_r <= 1'b0;
            result_r <= 8'h00;
            result_valid_r <= 1'b0;
            device_status_r <= 8'h00;
            ecc_result_status_r <= 8'h00;
            id_chip_count_r <= 4'd0;
            id_cell_levels_r <= 5'd0;
            id_page_kb_r <= 4'd0;
            id_block_kb_r <= 10'd0;
            id_wide_r <= 1'b0;
        end else begin
            op_done_r <= 1'b0;
            result_valid_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    op_ready_r <= 1'b1;
                    if (op_valid && op_ready_r) begin
                        op_ready_r <= 1'b0;
                        op_r <= op_code;
                        src_r <= op_src_addr;
                        dst_r <= op_dst_addr;
                        col_r <= op_column;
                        data_r <= op_data;
                        step_r <= 4'd0;
                        idx_r <= 3'd0;
                        err_r <= 1'b0;
                        // Cross-district copy-back is refused before any pin moves
                        if (op_code == `NCB_OP_COPY_PROG && op_src_addr[`NCB_SRC_DISTRICT_BIT]
                            != op_dst_addr[`NCB_SRC_DISTRICT_BIT]) begin
                            op_error_r <= 1'b1;
                            op_done_r <= 1'b1;
                        end else if (!ready_busy_pin && op_code != `NCB_OP_STATUS
                            && op_code != `NCB_OP_RESET) begin
                            op_error_r <= 1'b1;
                            op_done_r <= 1'b1;
                        end else begin
                            op_error_r <= 1'b0;
                            state_r <= S_ISSUE;
                        end
                    end
                end
                S_ISSUE: state_r <= S_WAIT;
                S_WAIT: begin
                    if (st_done) begin
                        if (st_kind == K_RD) begin
                            result_r <= st_rdata;
                            result_valid_r <= 1'b1;
                            if (op_r == `NCB_OP_STATUS) begin
                                device_status_r <= st_rdata;
                            end
                            if (op_r == `NCB_OP_ECC_STATUS) begin
                                ecc_result_status_r <= st_rdata;
                                if ((st_rdata[3:0] > `NCB_ECC_MAX_CORR &&
                                    st_rdata[3:0] != `NCB_ECC_UNCORR) ||
                                    st_rdata[7:4] > `NCB_ECC_SEC_MAX) begin
                                    err_r <= 1'b1;
                                end
                            end
                            if (op_r == `NCB_OP_READ_ID) begin
                                idx_r <= idx_r + 3'd1;
                                if (idx_r == 3'd2) begin
                                    id_chip_count_r <= 4'd1 << st_rdata[1:0];
                                    id_cell_levels_r <= 5'd2 << st_rdata[3:2];
                                end
                                if (idx_r == 3'd3) begin
                                    id_page_kb_r <= 4'd1 << st_rdata[1:0];
                                    id_block_kb_r <= 10'd64 << st_rdata[5:4];
                                    id_wide_r <= st_rdata[6];
                                end
                            end
                        end
                        if (last_step) begin
                            wait_r <= 32'h0000_0000;
                            state_r <= busy_after ? S_WB : S_DONE;
                        end else begin
                            if (!(op_r == `NCB_OP_READ_ID && st_kind == K_RD)) begin
                                step_r <= step_r + 4'd1;
                            end
                            state_r <= S_ISSUE;
                        end
                    end
                end
                S_WB: begin
                    // Device needs time before the busy pin falls
                    wait_r <= wait_r + 32'h0000_0001;
                    if (wait_r >= (`NCB_WB_CYC - 1)) begin
                        wait_r <= 32'h0000_0000;
                        state_r <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    wait_r <= wait_r + 32'h0000_0001;
                    if (ready_busy_pin) begin
                        state_r <= S_DONE;
                    end else if (wait_r >= `NCB_BUSY_TIMEOUT) begin
                        err_r <= 1'b1;
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    op_done_r <= 1'b1;
                    op_error_r <= err_r;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
    // Pins are re-registered so every top output comes from a flip-flop
    always @(posedge clk_sys) begin
        if (reset) begin
            cle <= 1'b0;
            ale <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            port_out <= 8'h00;
            port_oe <= 1'b0;
        end else begin
            cle <= s_cle;
            ale <= s_ale;
            write_strobe_n <= s_we_n;
            read_strobe_n <= s_re_n;
            port_out <= s_out;
            port_oe <= s_oe;
        end
    end
    ncb_strobe u_strobe (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(state_r == S_ISSUE),
        .kind(st_kind),
        .wdata(st_data),
        .port_in(port_in),
        .done_r(st_done),
        .rdata_r(st_rdata),
        .cle_r(s_cle),
        .ale_r(s_ale),
        .write_strobe_n_r(s_we_n),
        .read_strobe_n_r(s_re_n),
        .port_out_r(s_out),
        .port_oe_r(s_oe)
    );
endmodule // ncb_host

// [hdl/ncb_defs.vh]
// Purpose: Constants for the NAND copy-back / ID / status host controller
// Assumes: 10 MHz clk_sys, x8 NAND port
// Notes: Strobe and WB counts derive from nanosecond figures and the clock period; the busy timeout is a plain cycle count
`ifndef NCB_DEFS_VH
`define NCB_DEFS_VH
`define NCB_CMD_READ0 8'h00
`define NCB_CMD_CB_READ 8'h35
`define NCB_CMD_READ_CFM 8'h30
`define NCB_CMD_CB_DATA 8'h85
`define NCB_CMD_PROG_CFM 8'h10
`define NCB_CMD_STATUS 8'h70
`define NCB_CMD_STATUS2 8'h71
`define NCB_CMD_READ_ID 8'h90
`define NCB_CMD_ECC_STAT 8'h7A
`define NCB_CMD_RESET 8'hFF
// Operation codes at the user port
`define NCB_OP_COPY_READ 3'h0
`define NCB_OP_COPY_PROG 3'h1
`define NCB_OP_PATCH 3'h2
`define NCB_OP_READ_ID 3'h3
`define NCB_OP_STATUS 3'h4
`define NCB_OP_ECC_STATUS 3'h5
`define NCB_OP_RESET 3'h6
// Status byte fields
`define NCB_ST_FAIL 0
`define NCB_ST_REWRITE 3
`define NCB_ST_RDY_A 5
`define NCB_ST_RDY_B 6
`define NCB_ST_WP_N 7
// ECC status byte fields
`define NCB_ECC_RES_LSB 0
`define NCB_ECC_SEC_LSB 4
`define NCB_ECC_UNCORR 4'hF
`define NCB_ECC_MAX_CORR 4'h8
`define NCB_ECC_SEC_MAX 4'h7
// ID layout and copy-back district bit
`define NCB_ID_BYTES 3'd5
`define NCB_SRC_DISTRICT_BIT 6
// Timing
`define NCB_CLK_NS 100
`define NCB_STROBE_NS 100
`define NCB_STROBE_CYC (((`NCB_STROBE_NS + `NCB_CLK_NS - 1) / `NCB_CLK_NS) < 1 ? 1 : \
    ((`NCB_STROBE_NS + `NCB_CLK_NS - 1) / `NCB_CLK_NS))
`define NCB_WB_NS 200
`define NCB_WB_CYC ((`NCB_WB_NS + `NCB_CLK_NS - 1) / `NCB_CLK_NS)
`define NCB_BUSY_TIMEOUT 32'd100000
`endif

// [hdl/ncb_strobe.v]
// Purpose: One NAND bus cycle: command, address or data write, or data read
// Assumes: Port inputs synchronous to clk_sys
// Notes: Each strobe is held low NCB_STROBE_CYC and high NCB_STROBE_CYC
`timescale 1ns/100ps
`include "ncb_defs.vh"
module ncb_strobe (
    input wire clk_sys,
    input wire reset,
    input wire start,
    input wire [1:0] kind,
    input wire [7:0] wdata,
    input wire [7:0] port_in,
    output reg done_r,
    output reg [7:0] rdata_r,
    output reg cle_r,
    output reg ale_r,
    output reg write_strobe_n_r,
    output reg read_strobe_n_r,
    output reg [7:0] port_out_r,
    output reg port_oe_r
);
    // kind: 0 command, 1 address, 2 data write, 3 data read
    localparam S_IDLE = 2'd0;
    localparam S_LOW = 2'd1;
    localparam S_HIGH = 2'd2;
    reg [1:0] state_r;
    reg [7:0] cnt_r;
    reg [1:0] kind_r;
    always @(posedge clk_sys) begin
        if (reset) begin
            state_r <= S_IDLE;
            cnt_r <= 8'h00;
            kind_r <= 2'd0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            cle_r <= 1'b0;
            ale_r <= 1'b0;
            write_strobe_n_r <= 1'b1;
            read_strobe_n_r <= 1'b1;
            port_out_r <= 8'h00;
            port_oe_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        kind_r <= kind;
                        cle_r <= (kind == 2'd0);
                        ale_r <= (kind == 2'd1);
                        port_out_r <= wdata;
                        port_oe_r <= (kind != 2'd3);
                        write_strobe_n_r <= (kind == 2'd3);
                        read_strobe_n_r <= (kind != 2'd3);
                        cnt_r <= 8'h00;
                        state_r <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (cnt_r >= (`NCB_STROBE_CYC - 1)) begin
                        write_strobe_n_r <= 1'b1;
                        read_strobe_n_r <= 1'b1;
                        cnt_r <= 8'h00;
                        state_r <= S_HIGH;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                S_HIGH: begin
                    // Pins pass one more register, so the read byte settles an edge late
                    if (kind_r == 2'd3 && cnt_r == 8'h00) begin
                        rdata_r <= port_in;
                    end
                    if (cnt_r >= (`NCB_STROBE_CYC - 1)) begin
                        cle_r <= 1'b0;
                        ale_r <= 1'b0;
                        port_oe_r <= 1'b0;
                        done_r <= 1'b1;
                        state_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // ncb_strobe

// [bench/ncb_host_monitor.sv]
// Purpose: Pin-level checks for the NAND copy-back host controller
// Assumes: Bound to ncb_host, one clock domain
// Notes: Helper registers track the last command, address count and busy waits
`timescale 1ns/100ps
`include "ncb_defs.vh"
module ncb_host_monitor (
    input wire clk_sys,
    input wire reset,
    input wire op_valid,
    input wire op_ready_r,
    input wire op_done_r,
    input wire op_error_r,
    input wire [2:0] op_code,
    input wire [31:0] op_src_addr,
    input wire [31:0] op_dst_addr,
    input wire ready_busy_pin,
    input wire cle,
    input wire ale,
    input wire write_strobe_n,
    input wire read_strobe_n,
    input wire [7:0] port_out,
    input wire port_oe
);
    reg [7:0] last_cmd_r;
    reg [2:0] addr_cnt_r;
    reg wait_r;
    wire cmd_w = cle && !write_strobe_n;
    // Strobe is low for a single cycle, so each byte is counted once
    always @(posedge clk_sys) begin
        if (reset) begin
            last_cmd_r <= 8'h00;
            addr_cnt_r <= 3'h0;
            wait_r <= 1'b0;
        end else begin
            if (cmd_w) last_cmd_r <= port_out;
            if (cmd_w) addr_cnt_r <= 3'h0;
            else if (ale && !write_strobe_n) addr_cnt_r <= addr_cnt_r + 3'h1;
            if (cmd_w && port_out inside {`NCB_CMD_PROG_CFM, `NCB_CMD_CB_READ, `NCB_CMD_RESET})
                wait_r <= 1'b1;
            else if (op_done_r) wait_r <= 1'b0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence cmd_s(logic [7:0] v);
        cmd_w && port_out == v;
    endsequence
    sequence refused_s;
        op_valid && op_ready_r && (ready_busy_pin ? op_code == `NCB_OP_COPY_PROG &&
            op_src_addr[6] != op_dst_addr[6] : op_code == `NCB_OP_READ_ID);
    endsequence
    busy_command_a: assert property (
        cmd_w && !ready_busy_pin |-> port_out inside {`NCB_CMD_STATUS, `NCB_CMD_STATUS2,
            `NCB_CMD_RESET}) else $error("command sent while busy");
    refuse_answer_a: assert property (
        refused_s |-> ##[1:2] (op_done_r && op_error_r)) else $error("refusal not flagged");
    refuse_quiet_a: assert property (
        refused_s |=> (write_strobe_n && read_strobe_n && !port_oe)[*3])
        else $error("pins moved on refusal");
    read_release_a: assert property (
        !read_strobe_n |-> !port_oe) else $error("port driven in read strobe");
    busy_hold_a: assert property (
        wait_r && !ready_busy_pin |=> !op_done_r) else $error("done while busy");
    ready_done_a: assert property (
        wait_r && $rose(ready_busy_pin) |-> ##[1:6] op_done_r) else $error("done missing");
    confirm_order_a: assert property (
        cmd_s(`NCB_CMD_PROG_CFM) |-> last_cmd_r == `NCB_CMD_CB_DATA && addr_cnt_r == 3'h5)
        else $error("confirm out of order");
    read_order_a: assert property (
        cmd_s(`NCB_CMD_CB_READ) |-> last_cmd_r == `NCB_CMD_READ0 && addr_cnt_r == 3'h5)
        else $error("copy read out of order");
    id_address_a: assert property (
        cmd_s(`NCB_CMD_READ_ID) |-> ##[1:6] (ale && !write_strobe_n && port_out == 8'h00))
        else $error("id address missing");
endmodule  // ncb_host_monitor
bind ncb_host ncb_host_monitor mon (.clk_sys, .reset, .op_valid, .op_ready_r, .op_done_r,
    .op_error_r, .op_code, .op_src_addr, .op_dst_addr, .ready_busy_pin, .cle, .ale,
    .write_strobe_n, .read_strobe_n, .port_out, .port_oe);

// [bench/ncb_flash_model.sv]
// Purpose: Behavioural NAND device facing the host controller
// Assumes: Pins registered on clk_sys, one strobe cycle per byte
// Notes: Knobs are set by the bench; unwritten pages read a pattern
`timescale 1ns/100ps
`include "ncb_defs.vh"
module ncb_flash_model #(
    parameter int TBUSY = 20,
    parameter logic [7:0] MAKER = 8'h5A,  // Arbitrary value
    parameter logic [7:0] PART = 8'h3C,  // Arbitrary value
    parameter logic [7:0] FEAT = 8'h84
) (
    input wire logic clk_sys,
    input wire logic cle,
    input wire logic ale,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] port_out,
    output wire logic [7:0] port_in,
    output wire logic ready_busy_pin
);
    logic [7:0] mem [bit [47:0]];
    logic [7:0] bufm [int];
    logic [7:0] cmd = 8'hFF, val, last = 8'h00, id3 = 8'h00, id4 = 8'h00, ecc = 8'h00;
    logic wp_n = 1'b1, fail = 1'b0, rw = 1'b0, hold = 1'b0, hold_r = 1'b0;
    logic [23:0] row = 24'h0;
    logic [15:0] col = 16'h0;
    int na = 0, busy = 0, ptr = 0, viol = 0, progs = 0;
    wire rdy = busy == 0 && !hold;
    assign ready_busy_pin = rdy;
    // Released bus shows the inverse of the last byte, never a stale copy
    assign port_in = (!read_strobe_n || hold_r) ? val : ~last;
    function automatic logic [7:0] rd(input logic [23:0] r, input logic [15:0] c);
        return mem.exists({r, 8'h00, c}) ? mem[{r, 8'h00, c}] : r[7:0] ^ c[7:0] ^ 8'hA5;
    endfunction
    always @* begin
        case (cmd)
            `NCB_CMD_STATUS, `NCB_CMD_STATUS2: val = {wp_n, rdy, rdy, 1'b0, rw, 2'b00, fail};
            `NCB_CMD_ECC_STAT: val = ecc;
            default: val = ptr == 0 ? MAKER : ptr == 1 ? PART : ptr == 2 ? id3 : ptr == 3 ? id4 : FEAT;
        endcase
    end
    always @(posedge clk_sys) begin
        if (busy > 0) busy <= busy - 1;
        hold_r <= !read_strobe_n;
        if (!read_strobe_n || hold_r) last <= val;
        if (hold_r && read_strobe_n) ptr <= ptr + 1;
        if (!write_strobe_n && cle) begin
            if (!rdy && !(port_out inside {8'h70, 8'h71, 8'hFF})) viol++;
            if (port_out == `NCB_CMD_CB_READ) begin
                for (int c = 0; c < 4224; c++) bufm[c] = rd(row, c[15:0]);
                busy <= TBUSY;
            end
            if (port_out == `NCB_CMD_PROG_CFM && cmd == `NCB_CMD_CB_DATA) begin
                for (int c = 0; c < 4224; c++) mem[{row, 8'h00, c[15:0]}] = bufm[c];
                progs++;
                busy <= TBUSY;
            end
            if (port_out == `NCB_CMD_RESET) busy <= 2;
            if (port_out == `NCB_CMD_READ_ID) ptr <= 0;
            cmd <= port_out;
            na = 0;
        end else if (!write_strobe_n && ale) begin
            case (na)
                0: col[7:0] = port_out;
                1: col[15:8] = port_out;
                2: row[7:0] = port_out;
                3: row[15:8] = port_out;
                default: row[23:16] = port_out;
            endcase
            na++;
        end else if (!write_strobe_n && cmd == `NCB_CMD_CB_DATA) begin
            bufm[col] = port_out;
            col++;
        end
    end
endmodule  // ncb_flash_model

// [bench/tb.sv]
// Purpose: Self-checking bench for the NAND copy-back host controller
// Assumes: ncb_flash_model stands on the far side of the pins
// Notes: Rows, columns and bytes come from a fixed-seed LFSR
`timescale 1ns/100ps
`include "ncb_defs.vh"
module tb;
    localparam logic [7:0] MK = 8'h5A;  // Arbitrary value
    localparam logic [7:0] PT = 8'h3C;  // Arbitrary value
    localparam logic [7:0] FT = 8'h84;
    logic clk_sys = 0, reset = 1, op_valid = 0;
    logic [2:0] op_code = 0;
    logic [31:0] op_src_addr = 0, op_dst_addr = 0, lfsr_r = 32'h0000_0676, src;
    logic [15:0] op_column = 0, col;
    logic [7:0] op_data = 0, d, ids [5];
    wire [7:0] port_in, port_out, result_r, device_status_r, ecc_result_status_r;
    wire [3:0] id_chip_count_r, id_page_kb_r;
    wire [4:0] id_cell_levels_r;
    wire [9:0] id_block_kb_r;
    wire ready_busy_pin, op_ready_r, op_done_r, op_error_r, result_valid_r, id_wide_r;
    wire cle, ale, write_strobe_n, read_strobe_n, port_oe;
    int failures = 0, comparisons = 0, cycles = 0, p0;
    logic [7:0] rq [$];
    always #50 clk_sys = ~clk_sys;
    ncb_host dut (.clk_sys, .reset, .op_valid, .op_code, .op_src_addr, .op_dst_addr, .op_column,
        .op_data, .port_in, .ready_busy_pin, .op_ready_r, .op_done_r, .op_error_r, .result_r,
        .result_valid_r, .device_status_r, .ecc_result_status_r, .id_chip_count_r,
        .id_cell_levels_r, .id_page_kb_r, .id_block_kb_r, .id_wide_r, .cle, .ale,
        .write_strobe_n, .read_strobe_n, .port_out, .port_oe);
    ncb_flash_model #(.MAKER(MK), .PART(PT), .FEAT(FT)) dev (.clk_sys, .cle, .ale,
        .write_strobe_n, .read_strobe_n, .port_out, .port_in, .ready_busy_pin);
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] exp_status(input logic p, input logic r, input logic w,
        input logic f);
        return {p, r, r, 1'b0, w, 2'b00, f};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic run_op(input logic [2:0] c, input logic err);
        int n;
        n = 0;
        do @(posedge clk_sys); while (op_ready_r !== 1'b1 && ++n < 200);
        op_code <= c;
        op_valid <= 1'b1;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        n = 0;
        do @(posedge clk_sys); while (op_done_r !== 1'b1 && ++n < 3000);
        check("op done", n < 3000, 1'b1);
        // One more edge after op_done_r before op_error_r is checked; the last read byte is already queued
        @(posedge clk_sys);
        check("op error", op_error_r, err);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            stop_test();
        end
    end
    always @(posedge clk_sys) if (result_valid_r === 1'b1) rq.push_back(result_r);
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            dev.id3 = {4'b1001, i[1:0], i[1:0]};
            dev.id4 = {1'b0, i[0], i[1:0], 2'b01, i[1:0]};
            ids = '{MK, PT, dev.id3, dev.id4, FT};
            rq.delete();
            run_op(`NCB_OP_READ_ID, 1'b0);
            check("id count", rq.size(), 5);
            foreach (ids[k]) if (k < rq.size()) check("id byte", rq[k], ids[k]);
            check("chips", id_chip_count_r, 4'd1 << i[1:0]);
            check("levels", id_cell_levels_r, 5'd2 << i[1:0]);
            check("page kb", id_page_kb_r, 4'd1 << i[1:0]);
            check("block kb", id_block_kb_r, 10'd64 << i[1:0]);
            check("width", id_wide_r, i[0]);
        end
        for (int i = 0; i < 3; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            src = {8'h00, lfsr_r[23:0]};
            col = lfsr_r[31:16] % 16'd4224;
            d = lfsr_r[7:0];
            op_src_addr <= src;
            op_dst_addr <= src ^ 32'h0000_0080;
            op_column <= col;
            op_data <= d;
            run_op(`NCB_OP_COPY_READ, 1'b0);
            check("buffer", dev.bufm[col], dev.rd(src[23:0], col));
            dev.wp_n = lfsr_r[8];
            dev.rw = lfsr_r[9];
            dev.fail = lfsr_r[10];
            run_op(`NCB_OP_STATUS, 1'b0);
            check("status", device_status_r & 8'hFD,
                exp_status(lfsr_r[8], 1'b1, lfsr_r[9], lfsr_r[10]));
            dev.wp_n = 1'b1;
            dev.rw = 1'b0;
            dev.fail = 1'b0;
            run_op(`NCB_OP_PATCH, 1'b0);
            run_op(`NCB_OP_COPY_PROG, 1'b0);
            check("patched", dev.rd(src[23:0] ^ 24'h80, col), d);
            check("copied", dev.rd(src[23:0] ^ 24'h80, col ^ 16'h1),
                dev.rd(src[23:0], col ^ 16'h1));
        end
        p0 = dev.progs;
        op_dst_addr <= src ^ 32'h0000_0040;
        run_op(`NCB_OP_COPY_PROG, 1'b1);
        check("programs", dev.progs, p0);
        dev.hold = 1'b1;
        run_op(`NCB_OP_READ_ID, 1'b1);
        run_op(`NCB_OP_STATUS, 1'b0);
        check("busy status", device_status_r & 8'hFD, exp_status(1'b1, 1'b0, 1'b0, 1'b0));
        dev.hold = 1'b0;
        for (int k = 0; k < 12; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            d = {1'b0, lfsr_r[2:0], k < 9 ? k[3:0] : 4'hF};
            if (k == 10) d = 8'h09;
            if (k == 11) d = 8'h80;
            dev.ecc = d;
            run_op(`NCB_OP_ECC_STATUS, k > 9);
            if (k < 10) check("ecc", ecc_result_status_r, d);
        end
        run_op(`NCB_OP_RESET, 1'b0);
        check("violations", dev.viol, 0);
        stop_test();
    end
endmodule  // tb
